// file: rtl/card_info_register_bank.v
// card information register bank: operating conditions, identity and card-specific words
// assumes an avalon-mm master on clk, synchronous reset, and a start of init from software
//
// Overview of operation
// [R1] voltage window bits 15 to 23 of the conditions word read as one
// [R2] reserved conditions bits 0 to 14 and 25 to 29 read as zero
// [R3] ready bit 31 stays low while the power-up routine runs
// [R4] ready bit 31 sets only after power-up and initialisation complete
// [R5] capacity bit 30 reads one; host trusts it only when ready is set
// [R6] bit 24 reads one: switch to 1.8 V signalling accepted
// [R7] identity holds maker, application code, product label and revision fields
// [R8] identity holds serial in 55..24, date in 19..8, 23..20 zero
// [R9] identity ends in checksum at 7..1 and a constant one at bit 0
// [R10] card-specific layout version 01 at 127..126, then six zero bits
// [R11] read access time 0E at 119..112, clock count zero at 111..104
// [R12] transfer rate 5A at 103..96, command classes 5B5 at 95..84
// [R13] read block length code 9 at 83..80
// [R14] partial read, misalignment and driver-stage bits 79..76 read zero
// [R15] single-block erase one at bit 46, sector size 7F at 45..39
// [R16] protect group size zero at 38..32, group enable zero at bit 31
// [R17] write block length code 9 at 25..22
// [R18] partial-block write bit 21 reads zero
// [R19] no driver-stage register; writes to it have no effect
// [R20] checksum is crc7, polynomial x^7+x^3+1, over the upper 120 bits
// [R21] conditions and identity words are read-only apart from status bits
`timescale 1ns/1ps
`include "card_info_map.vh"

module card_info_register_bank #(
  parameter POWERUP_CYCLES = (`POWERUP_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output reg  [1:0]  response,
  output wire        card_ready
);

  localparam INIT_CYCLES = (`INIT_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  localparam ST_POWERUP = 2'h0;
  localparam ST_IDLE    = 2'h1;
  localparam ST_INIT    = 2'h2;
  localparam ST_READY   = 2'h3;

  // ------------------------------------------------------------
  // checksum
  // ------------------------------------------------------------
  function [6:0] crc7;
    input [119:0] data;
    integer i;
    reg [6:0] c;
    reg       fb;
    begin
      c = 7'h00;
      for (i = 119; i >= 0; i = i - 1) begin
        fb = data[i] ^ c[6];
        c  = {c[5:0], 1'b0};
        if (fb) begin
          c = c ^ `CRC7_POLY;
        end
      end
      crc7 = c;
    end
  endfunction

  // ------------------------------------------------------------
  // identity record fields
  // ------------------------------------------------------------
  // every field is a constant; serial and date stay zero so that a
  // production flow can patch them without touching the rest of the record
  wire [7:0]   maker_code;
  wire [15:0]  application_code;
  wire [39:0]  product_label;
  wire [7:0]   product_revision_code;
  wire [31:0]  serial_number;
  wire [3:0]   ident_reserved;
  wire [11:0]  manufacture_date;
  wire [119:0] ident_body;
  wire [6:0]   ident_checksum;
  wire         ident_stop_bit;
  wire [127:0] card_identity_record;

  assign maker_code            = `ID_MAKER;      // [R7]
  assign application_code      = `ID_APP_CODE;   // [R7]
  assign product_label         = `ID_LABEL;      // [R7]
  assign product_revision_code = `ID_REVISION;   // [R7]
  assign serial_number         = `ID_SERIAL;     // [R8]
  assign ident_reserved        = 4'h0;           // [R8]
  assign manufacture_date      = `ID_DATE;       // [R8]

  assign ident_body = {maker_code,
                       application_code,
                       product_label,
                       product_revision_code,
                       serial_number,
                       ident_reserved,
                       manufacture_date};

  // the checksum folds to a constant, so it costs no logic at run time
  assign ident_checksum       = crc7(ident_body);  // [R9] [R20]
  assign ident_stop_bit       = 1'b1;              // [R9]
  assign card_identity_record = {ident_body, ident_checksum, ident_stop_bit};

  // ------------------------------------------------------------
  // card-specific parameter fields
  // ------------------------------------------------------------
  // only the upper fields are modelled; the low 21 bits read zero
  wire [1:0]   record_layout_version;
  wire [5:0]   layout_reserved;
  wire [7:0]   read_access_time;
  wire [7:0]   read_access_clock_count;
  wire [7:0]   transfer_rate_code;
  wire [11:0]  command_classes;
  wire [3:0]   read_block_length;
  wire         partial_read_allowed;
  wire         write_misalign_allowed;
  wire         read_misalign_allowed;
  wire         driver_stage_present;
  wire [5:0]   size_reserved;
  wire [21:0]  device_size;
  wire         size_tail_reserved;
  wire         single_block_erase_enable;
  wire [6:0]   erase_sector_size;
  wire [6:0]   protect_group_size;
  wire         protect_group_enable;
  wire [1:0]   speed_reserved;
  wire [2:0]   write_speed_factor;
  wire [3:0]   write_block_length;
  wire         partial_write_allowed;
  wire [20:0]  lower_fields;
  wire [127:0] card_specific_parameters;

  assign record_layout_version     = `SP_LAYOUT_VER;     // [R10]
  assign layout_reserved           = 6'h00;              // [R10]
  assign read_access_time          = `SP_READ_TIME;      // [R11]
  assign read_access_clock_count   = `SP_READ_CLKS;      // [R11]
  assign transfer_rate_code        = `SP_TRAN_SPEED;     // [R12]
  assign command_classes           = `SP_CMD_CLASSES;    // [R12]
  assign read_block_length         = `SP_READ_BLK_LEN;   // [R13]
  assign partial_read_allowed      = 1'b0;               // [R14]
  assign write_misalign_allowed    = 1'b0;               // [R14]
  assign read_misalign_allowed     = 1'b0;               // [R14]
  // no driver-stage register exists, so its presence bit must read zero
  assign driver_stage_present      = 1'b0;               // [R14] [R19]
  assign size_reserved             = 6'h00;
  assign device_size               = `SP_DEV_SIZE;
  assign size_tail_reserved        = 1'b0;
  assign single_block_erase_enable = `SP_BLK_ERASE_EN;   // [R15]
  assign erase_sector_size         = `SP_SECTOR_SIZE;    // [R15]
  assign protect_group_size        = `SP_PROT_GRP_SIZE;  // [R16]
  assign protect_group_enable      = `SP_PROT_GRP_EN;    // [R16]
  assign speed_reserved            = 2'h0;
  assign write_speed_factor        = `SP_WRITE_FACTOR;
  assign write_block_length        = `SP_WRITE_BLK_LEN;  // [R17]
  assign partial_write_allowed     = 1'b0;               // [R18]
  assign lower_fields              = 21'h000000;

  assign card_specific_parameters = {record_layout_version,
                                     layout_reserved,
                                     read_access_time,
                                     read_access_clock_count,
                                     transfer_rate_code,
                                     command_classes,
                                     read_block_length,
                                     partial_read_allowed,
                                     write_misalign_allowed,
                                     read_misalign_allowed,
                                     driver_stage_present,
                                     size_reserved,
                                     device_size,
                                     size_tail_reserved,
                                     single_block_erase_enable,
                                     erase_sector_size,
                                     protect_group_size,
                                     protect_group_enable,
                                     speed_reserved,
                                     write_speed_factor,
                                     write_block_length,
                                     partial_write_allowed,
                                     lower_fields};

  // ------------------------------------------------------------
  // power-up and initialisation sequencer
  // ------------------------------------------------------------
  reg [1:0]  state;
  reg [31:0] count;
  reg        init_request;

  always @(posedge clk) begin
    if (reset) begin
      state <= ST_POWERUP;
      count <= 32'h00000000;
    end else begin
      case (state)
        ST_POWERUP: begin
          // busy until the power-up routine has run its full time
          if (count == POWERUP_CYCLES - 1) begin  // [R3]
            state <= ST_IDLE;
            count <= 32'h00000000;
          end else begin
            count <= count + 32'h00000001;
          end
        end
        ST_IDLE: begin
          if (init_request) begin
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (count == INIT_CYCLES - 1) begin     // [R4]
            state <= ST_READY;
            count <= 32'h00000000;
          end else begin
            count <= count + 32'h00000001;
          end
        end
        ST_READY: begin
          state <= ST_READY;
        end
        default: begin
          state <= ST_POWERUP;
          count <= 32'h00000000;
        end
      endcase
    end
  end

  assign card_ready = (state == ST_READY);  // [R4]

  // ------------------------------------------------------------
  // operating-conditions word fields
  // ------------------------------------------------------------
  // the capacity flag reads one at all times; the host must ignore it
  // until the ready bit is set, so no gating against ready is done here
  wire        capacity_class_flag;
  wire [4:0]  opc_high_reserved;
  wire        low_signalling_accepted;
  wire [8:0]  voltage_window;
  wire [14:0] opc_low_reserved;
  wire [31:0] operating_conditions_word;

  assign capacity_class_flag     = 1'b1;     // [R5]
  assign opc_high_reserved       = 5'h00;    // [R2]
  assign low_signalling_accepted = 1'b1;     // [R6]
  assign voltage_window          = 9'h1FF;   // [R1]
  // bit 7, the low-voltage range bit, sits in this zero field
  assign opc_low_reserved        = 15'h0000; // [R2]

  assign operating_conditions_word = {card_ready,               // [R3] [R4]
                                      capacity_class_flag,
                                      opc_high_reserved,
                                      low_signalling_accepted,
                                      voltage_window,
                                      opc_low_reserved};

  // ------------------------------------------------------------
  // register map, byte offsets on the avalon bus
  // ------------------------------------------------------------
  // 0x00        operating-conditions word, read-only
  // 0x10..0x1C  identity record, lowest bits at lowest offset
  // 0x20..0x2C  card-specific parameters, lowest bits at lowest offset
  // 0x30        control: write bit 0 to start init; read bit 0 ready,
  //             bit 1 init running
  // 0x34        driver-stage slot, absent: reads zero, writes dropped
  // anything else answers with a decode error and zero data

  // ------------------------------------------------------------
  // avalon-mm slave: one cycle of wait, answer at the second edge
  // ------------------------------------------------------------
  reg pending;
  assign waitrequest = (read | write) & ~pending;

  wire valid_addr = (address == `OFS_OPCOND) ||
                    (address >= `OFS_IDENT0 && address <= `OFS_DRIVER_STAGE &&
                     address[1:0] == 2'h0);

  reg [31:0] next_readdata;
  always @* begin
    next_readdata = 32'h00000000;
    case (address)
      `OFS_OPCOND:       next_readdata = operating_conditions_word;
      `OFS_IDENT0:       next_readdata = card_identity_record[31:0];
      `OFS_IDENT1:       next_readdata = card_identity_record[63:32];
      `OFS_IDENT2:       next_readdata = card_identity_record[95:64];
      `OFS_IDENT3:       next_readdata = card_identity_record[127:96];
      `OFS_SPEC0:        next_readdata = card_specific_parameters[31:0];
      `OFS_SPEC1:        next_readdata = card_specific_parameters[63:32];
      `OFS_SPEC2:        next_readdata = card_specific_parameters[95:64];
      `OFS_SPEC3:        next_readdata = card_specific_parameters[127:96];
      `OFS_CONTROL:      next_readdata = {30'h00000000, state == ST_INIT, card_ready};
      // driver-stage register is absent: reads zero, writes dropped
      `OFS_DRIVER_STAGE: next_readdata = 32'h00000000;  // [R19]
      default:           next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      pending      <= 1'b0;
      readdata     <= 32'h00000000;
      response     <= 2'h0;
      init_request <= 1'b0;
    end else begin
      pending      <= (read | write) & ~pending;
      init_request <= 1'b0;
      if (read & ~pending) begin
        readdata <= next_readdata;
        response <= valid_addr ? 2'h0 : 2'h3;
      end
      if (write & ~pending) begin
        response <= valid_addr ? 2'h0 : 2'h3;
        // only the control word accepts writes; record words ignore them
        // a start request before power-up is done is dropped, not queued
        if (address == `OFS_CONTROL && byteenable[0] && writedata[0] &&
            state == ST_IDLE) begin  // [R21]
          init_request <= 1'b1;
        end
      end
    end
  end

endmodule

// file: include/card_info_map.vh
// constants for the card information register bank: offsets, fields, fixed values, timing
// assumes inclusion by bare name from the design file
`ifndef CARD_INFO_MAP_VH
`define CARD_INFO_MAP_VH

// ------------------------------------------------------------
// avalon word offsets (byte addresses, one aligned word each)
// ------------------------------------------------------------
`define OFS_OPCOND        8'h00
`define OFS_IDENT0        8'h10
`define OFS_IDENT1        8'h14
`define OFS_IDENT2        8'h18
`define OFS_IDENT3        8'h1C
`define OFS_SPEC0         8'h20
`define OFS_SPEC1         8'h24
`define OFS_SPEC2         8'h28
`define OFS_SPEC3         8'h2C
`define OFS_CONTROL       8'h30
`define OFS_DRIVER_STAGE  8'h34

// ------------------------------------------------------------
// operating-conditions word fields
// ------------------------------------------------------------
`define OPC_VOLT_LO       15
`define OPC_VOLT_HI       23
`define OPC_LOW_SIG_BIT   24
`define OPC_CAP_BIT       30
`define OPC_READY_BIT     31
`define OPC_VOLT_MASK     32'h00FF8000

// ------------------------------------------------------------
// identity record contents (arbitrary neutral identity values)
// ------------------------------------------------------------
`define ID_MAKER          8'h5C
`define ID_APP_CODE       16'h7E21
`define ID_LABEL          40'h4142434445
`define ID_REVISION       8'h11
`define ID_SERIAL         32'h00000000
`define ID_DATE           12'h000
`define CRC7_POLY         7'h09

// ------------------------------------------------------------
// card-specific parameters contents
// ------------------------------------------------------------
`define SP_LAYOUT_VER     2'h1
`define SP_READ_TIME      8'h0E
`define SP_READ_CLKS      8'h00
`define SP_TRAN_SPEED     8'h5A
`define SP_CMD_CLASSES    12'h5B5
`define SP_READ_BLK_LEN   4'h9
`define SP_DEV_SIZE       22'h01D27F
`define SP_BLK_ERASE_EN   1'h1
`define SP_SECTOR_SIZE    7'h7F
`define SP_PROT_GRP_SIZE  7'h00
`define SP_PROT_GRP_EN    1'h0
`define SP_WRITE_FACTOR   3'h2
`define SP_WRITE_BLK_LEN  4'h9

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define POWERUP_TIME_US   1000
`define INIT_TIME_US      1

`endif

// file: dv/card_host_model.sv
// host-side avalon-mm master model for the card information bank
// assumes one clock; the bench issues every transfer through xfer
`timescale 1ns/1ps
module card_host_model (
  input  wire        clk,
  input  wire [31:0] readdata,
  input  wire        waitrequest,
  input  wire [1:0]  response,
  output reg  [7:0]  address,
  output reg         read,
  output reg         write,
  output reg  [31:0] writedata,
  output reg  [3:0]  byteenable
);
  reg hung = 1'b0;
  initial begin
    {address, read, write, writedata, byteenable} = {8'h00, 2'h0, 32'h0, 4'hF};
  end
  // request held until the edge that sees waitrequest low; data taken there
  task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] q, output [1:0] rs);
    integer k;
    begin
      @(posedge clk);
      {address, read, write, writedata} <= {a, ~w, w, wd};
      @(posedge clk);
      for (k = 0; k < 20 && waitrequest !== 1'b0; k = k + 1)
        @(posedge clk);
      hung = (k == 20);
      q = readdata;
      rs = response;
      {read, write} <= 2'h0;
    end
  endtask
endmodule

// file: dv/card_info_checker.sv
// port assertions for the card information register bank
// assumes the bind below; one clock, synchronous reset
`timescale 1ns/1ps
module card_info_checker #(
  parameter POWERUP_CYCLES = 20
) (
  input wire        clk,
  input wire        reset,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire [1:0]  response,
  input wire        card_ready
);
  integer cnt;
  wire    rd_done = read && !waitrequest;
  // saturating so a long run cannot wrap back under the power-up bound
  always @(posedge clk) begin
    if (reset)
      cnt <= 0;
    else if (cnt < 1000000)
      cnt <= cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_first_wait: assert property ($rose(read | write) |-> waitrequest)
    else $error("no wait cycle");
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait too long");
  a_opc_fixed: assert property (rd_done && address == 8'h00 |-> readdata[30:0] == 31'h41FF8000)
    else $error("conditions word fixed bits");
  a_ident_tail: assert property (rd_done && address == 8'h10 |-> readdata[23:20] == 4'h0 && readdata[0])
    else $error("identity low word");
  a_spec_top: assert property (rd_done && address == 8'h2C |-> readdata == 32'h400E005A)
    else $error("spec top word");
  a_ready_early: assert property (card_ready |-> cnt > POWERUP_CYCLES + 100)
    else $error("ready too early");
  a_ready_hold: assert property (card_ready |=> card_ready)
    else $error("ready dropped");
  a_ready_reset: assert property ($fell(reset) |-> !card_ready)
    else $error("ready after reset");
endmodule
bind card_info_register_bank card_info_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk_u (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .response(response), .card_ready(card_ready));

// file: dv/card_info_register_bank_test.sv
// self-checking bench for the card information register bank
// assumes the host model drives the bus; power-up count shortened by parameter
`timescale 1ns/1ps
module card_info_register_bank_test;
  localparam P = 20;
  reg          clk = 1'b0;
  reg          reset = 1'b1;
  wire [7:0]   address;
  wire         read;
  wire         write;
  wire [31:0]  writedata;
  wire [3:0]   byteenable;
  wire [31:0]  readdata;
  wire         waitrequest;
  wire [1:0]   response;
  wire         card_ready;
  integer      n_mismatch = 0;
  integer      compares = 0;
  integer      i;
  reg  [31:0]  d;
  reg  [1:0]   r;
  reg  [255:0] rec;
  always #5 clk = ~clk;
  card_info_register_bank #(.POWERUP_CYCLES(P)) dut_u (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .card_ready(card_ready));
  card_host_model host_u (.clk(clk), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));
  function [6:0] crc7(input [119:0] v);
    integer k;
    begin
      crc7 = 7'h00;
      for (k = 119; k >= 0; k = k - 1)
        crc7 = {crc7[5:0], 1'b0} ^ ((v[k] ^ crc7[6]) ? 7'h09 : 7'h00);
    end
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        $display("[ERR] %s expected %h seen %h", nm, e, g);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    if (host_u.hung) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end
  initial begin
    rec[127:0] = {8'h5C, 16'h7E21, 40'h4142434445, 8'h11, 56'h0};
    rec[7:0] = {crc7(rec[127:8]), 1'b1};
    rec[255:128] = {2'h1, 6'h0, 8'h0E, 8'h00, 8'h5A, 12'h5B5, 4'h9, 10'h0, 22'h01D27F,
      2'h1, 7'h7F, 7'h00, 1'h0, 2'h0, 3'h2, 4'h9, 22'h0};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    host_u.xfer(1'b0, 8'h00, 32'h0, d, r);
    chk("busy word", 32'h41FF8000, d);
    // an init request during power-up is dropped, so control must stay idle
    host_u.xfer(1'b1, 8'h30, 32'h1, d, r);
    repeat (P) @(posedge clk);
    host_u.xfer(1'b0, 8'h30, 32'h0, d, r);
    chk("control", 32'h0, {30'h0, d[1:0]});
    host_u.xfer(1'b1, 8'h30, 32'h1, d, r);
    repeat (90) @(posedge clk);
    host_u.xfer(1'b0, 8'h00, 32'h0, d, r);
    chk("busy in init", 32'h41FF8000, d);
    host_u.xfer(1'b0, 8'h30, 32'h0, d, r);
    chk("control init", 32'h2, d);
    for (i = 0; i < 40 && d[31] !== 1'b1; i = i + 1)
      host_u.xfer(1'b0, 8'h00, 32'h0, d, r);
    chk("ready word", 32'hC1FF8000, d);
    chk("ready pin", 32'h1, {31'h0, card_ready});
    host_u.xfer(1'b1, 8'h00, 32'h0, d, r);
    chk("ro write resp", 32'h0, {30'h0, r});
    host_u.xfer(1'b1, 8'h14, 32'h0, d, r);
    host_u.xfer(1'b1, 8'h34, 32'hFFFFFFFF, d, r);
    chk("stage write resp", 32'h0, {30'h0, r});
    for (i = 0; i < 8; i = i + 1) begin
      host_u.xfer(1'b0, 8'h10 + 8'(4 * i), 32'h0, d, r);
      chk("rec", rec[32*i+:32], d);
      chk("rec resp", 32'h0, {30'h0, r});
    end
    host_u.xfer(1'b0, 8'h00, 32'h0, d, r);
    chk("word kept", 32'hC1FF8000, d);
    host_u.xfer(1'b0, 8'h34, 32'h0, d, r);
    chk("driver stage", 32'h0, d);
    for (i = 0; i < 2; i = i + 1) begin
      host_u.xfer(1'b0, (i == 0) ? 8'h04 : 8'h38, 32'h0, d, r);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", 32'h3, {30'h0, r});
    end
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pin after reset", 32'h0, {31'h0, card_ready});
    host_u.xfer(1'b0, 8'h00, 32'h0, d, r);
    chk("busy again", 32'h41FF8000, d);
    summarize;
  end
endmodule
